// ===== tcc_pkg.sv
// shared constants for the 8-bit timer/compare core
package tcc_pkg;
   localparam int          TCC_DW            = 8;
   localparam logic [11:0] TCC_OFF_CTRL_A    = 12'h000;
   localparam logic [11:0] TCC_OFF_CTRL_B    = 12'h004;
   localparam logic [11:0] TCC_OFF_COUNT     = 12'h008;
   localparam logic [11:0] TCC_OFF_CMP_A     = 12'h00c;
   localparam logic [11:0] TCC_OFF_CMP_B     = 12'h010;
   localparam logic [11:0] TCC_OFF_MASK      = 12'h014;
   localparam logic [11:0] TCC_OFF_FLAG      = 12'h018;
   localparam logic [11:0] TCC_OFF_SVC       = 12'h01c;
   // control a fields
   localparam int          TCC_CA_WGM_LO     = 0;
   localparam int          TCC_CA_COMB_LO    = 4;
   localparam int          TCC_CA_COMA_LO    = 6;
   // control b fields
   localparam int          TCC_CB_CS_LO      = 0;
   localparam int          TCC_CB_WGM2       = 3;
   localparam int          TCC_CB_FOCB       = 6;
   localparam int          TCC_CB_FOCA       = 7;
   // flag and mask bits
   localparam int          TCC_FL_OVF        = 0;
   localparam int          TCC_FL_CMPA       = 1;
   localparam int          TCC_FL_CMPB       = 2;
   localparam logic [7:0]  TCC_RST_BYTE      = 8'h00;
   localparam logic [2:0]  TCC_CS_STOP       = 3'h0;
   localparam logic [7:0]  TCC_BOTTOM        = 8'h00;
   localparam logic [7:0]  TCC_MAX           = 8'hff;
   // clock select codes; 1..5 are prescaler taps
   localparam logic [2:0]  TCC_CS_EXT_FALL   = 3'h6;
   localparam logic [2:0]  TCC_CS_EXT_RISE   = 3'h7;
   // waveform modes
   localparam logic [2:0]  TCC_WM_NORMAL     = 3'h0;
   localparam logic [2:0]  TCC_WM_PCPWM      = 3'h1;
   localparam logic [2:0]  TCC_WM_CTC        = 3'h2;
   localparam logic [2:0]  TCC_WM_FAST       = 3'h3;
   localparam logic [2:0]  TCC_WM_PCPWM_A    = 3'h5;
   localparam logic [2:0]  TCC_WM_FAST_A     = 3'h7;
endpackage : tcc_pkg

// ===== tcc_tick.sv
// clock select: prescaled tick or external pin edge
`timescale 1ns/1ps
module tcc_tick
   import tcc_pkg::*;
(
   // system
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // control
   input  wire logic [2:0] clock_source_select,
   input  wire logic [4:0] prescale_taps,
   input  wire logic       external_count_pin,
   // tick
   output logic            timer_tick
);
   typedef struct packed {
      logic pin_q;
   } tcc_tick_st_t;

   tcc_tick_st_t s_q;
   tcc_tick_st_t s_d;

   always_comb begin
      s_d       = s_q;
      s_d.pin_q = external_count_pin;
      timer_tick = 1'b0;
      unique case (clock_source_select)
         TCC_CS_STOP:     timer_tick = 1'b0;
         TCC_CS_EXT_FALL: timer_tick = s_q.pin_q & ~external_count_pin;
         TCC_CS_EXT_RISE: timer_tick = ~s_q.pin_q & external_count_pin;
         default:         timer_tick = prescale_taps[clock_source_select - 3'h1];
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tcc_tick

// ===== tcc_wave.sv
// one output compare unit: buffer, match, flag and output
`timescale 1ns/1ps
module tcc_wave
   import tcc_pkg::*;
(
   // system
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // counter state
   input  wire logic       timer_tick,
   input  wire logic [7:0] count,
   input  wire logic       up,
   input  wire logic       buffered,
   input  wire logic       fast_pwm,
   input  wire logic       pc_pwm,
   input  wire logic       at_top,
   input  wire logic       at_bottom,
   input  wire logic       block_match,
   input  wire logic [1:0] compare_output_action,
   // cpu side
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   input  wire logic       force_compare_strobe,
   input  wire logic       flag_clr,
   // results
   output logic [7:0]      cpu_view,
   output logic [7:0]      compare_value_reg,
   output logic            match,
   output logic            flag,
   output logic            pin
);
   typedef struct packed {
      logic [7:0] buf_q;
      logic [7:0] cmp_q;
      logic       flag_q;
      logic       out_q;
   } tcc_wave_st_t;

   tcc_wave_st_t s_q;
   tcc_wave_st_t s_d;
   logic         hit;

   assign match             = (count == s_q.cmp_q);
   assign compare_value_reg = s_q.cmp_q;
   assign flag              = s_q.flag_q;
   assign pin               = s_q.out_q;
   assign cpu_view          = buffered ? s_q.buf_q : s_q.cmp_q;

   always_comb begin
      s_d = s_q;
      hit = timer_tick & match & ~block_match;
      if (wr_en) begin
         s_d.buf_q = wr_data;
         if (!buffered) begin
            s_d.cmp_q = wr_data;
         end
      end
      if (buffered && timer_tick && (fast_pwm ? at_bottom : at_top)) begin
         s_d.cmp_q = s_q.buf_q;
      end
      if (flag_clr) begin
         s_d.flag_q = 1'b0;
      end
      if (hit) begin
         s_d.flag_q = 1'b1;
      end
      if (!fast_pwm && !pc_pwm) begin
         if (hit || force_compare_strobe) begin
            unique case (compare_output_action)
               2'h0: s_d.out_q = s_q.out_q;
               2'h1: s_d.out_q = ~s_q.out_q;
               2'h2: s_d.out_q = 1'b0;
               2'h3: s_d.out_q = 1'b1;
            endcase
         end
      end else if (compare_output_action[1] && timer_tick) begin
         if (hit) begin
            s_d.out_q = fast_pwm ? compare_output_action[0] : (compare_output_action[0] ^ ~up);
         end else if (fast_pwm && at_bottom) begin
            s_d.out_q = ~compare_output_action[0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_flag_on_match: assert property (@(posedge clk_sys) disable iff (rst)
      (timer_tick && match && !block_match) |=> flag) else $error("compare flag not set");
   a_flag_clear_write: assert property (@(posedge clk_sys) disable iff (rst)
      (flag_clr && !(timer_tick && match && !block_match)) |=> !flag) else $error("flag not cleared");
   a_direct_write: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_en && !buffered && !(timer_tick && (fast_pwm ? at_bottom : at_top)))
      |=> compare_value_reg == $past(wr_data)) else $error("direct compare write lost");
endmodule : tcc_wave

// ===== tcc_core.sv
// 8-bit timer/counter with two compare units and apb registers
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tcc_core
   import tcc_pkg::*;
#(
   parameter int DW = tcc_pkg::TCC_DW
)
(
   // system
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // timer pins
   input  wire logic [4:0]  prescale_taps,
   input  wire logic        external_count_pin,
   output logic             compare_output_pin_a,
   output logic             compare_output_pin_b,
   // interrupt requests and service acknowledges
   output logic             irq_overflow,
   output logic             irq_compare_a,
   output logic             irq_compare_b,
   input  wire logic        svc_overflow,
   input  wire logic        svc_compare_a,
   input  wire logic        svc_compare_b
);
   typedef enum logic [1:0] {
      TCC_DIR_UP   = 2'b01,
      TCC_DIR_DOWN = 2'b10
   } tcc_dir_t;

   typedef struct packed {
      logic [7:0] ctrl_a_q;
      logic [7:0] ctrl_b_q;
      logic [DW-1:0] count_q;
      logic [2:0] mask_q;
      logic       ovf_q;
      logic       block_q;
      tcc_dir_t   dir_q;
      logic [31:0] rdata_q;
      logic        err_q;
   } tcc_core_st_t;

   tcc_core_st_t s_q;
   tcc_core_st_t s_d;

   logic        timer_tick;
   logic [2:0]  waveform_mode_select;
   logic        fast_pwm;
   logic        pc_pwm;
   logic        top_is_a;
   logic [7:0]  top_val;
   logic        at_top;
   logic        at_bottom;
   logic        at_max;
   logic        acc;
   logic        wr;
   logic        wr_count;
   logic        wr_cmp_a;
   logic        wr_cmp_b;
   logic        clr_a;
   logic        clr_b;
   logic        force_a;
   logic        force_b;
   logic [7:0]  view_a;
   logic [7:0]  view_b;
   logic [7:0]  cmp_a;
   logic        match_a;
   logic        match_b;
   logic        flag_a;
   logic        flag_b;
   logic        hit_ovf;
   logic        mapped;

   assign waveform_mode_select = {s_q.ctrl_b_q[TCC_CB_WGM2], s_q.ctrl_a_q[TCC_CA_WGM_LO +: 2]};
   assign fast_pwm  = (waveform_mode_select == TCC_WM_FAST) || (waveform_mode_select == TCC_WM_FAST_A);
   assign pc_pwm    = (waveform_mode_select == TCC_WM_PCPWM) || (waveform_mode_select == TCC_WM_PCPWM_A);
   assign top_is_a  = (waveform_mode_select == TCC_WM_CTC) || waveform_mode_select[2];
   assign top_val   = top_is_a ? cmp_a : TCC_MAX;
   assign at_top    = (s_q.count_q == top_val);
   assign at_bottom = (s_q.count_q == TCC_BOTTOM);
   assign at_max    = (s_q.count_q == TCC_MAX);

   // apb decode; zero wait states
   assign acc      = psel & penable;
   assign wr       = acc & pwrite & pstrb[0];
   assign wr_count = wr & (paddr == TCC_OFF_COUNT);
   assign wr_cmp_a = wr & (paddr == TCC_OFF_CMP_A);
   assign wr_cmp_b = wr & (paddr == TCC_OFF_CMP_B);
   assign clr_a    = (wr & (paddr == TCC_OFF_FLAG) & pwdata[TCC_FL_CMPA]) | svc_compare_a;
   assign clr_b    = (wr & (paddr == TCC_OFF_FLAG) & pwdata[TCC_FL_CMPB]) | svc_compare_b;
   assign force_a  = wr & (paddr == TCC_OFF_CTRL_B) & pwdata[TCC_CB_FOCA] & ~fast_pwm & ~pc_pwm;
   assign force_b  = wr & (paddr == TCC_OFF_CTRL_B) & pwdata[TCC_CB_FOCB] & ~fast_pwm & ~pc_pwm;
   assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= TCC_OFF_SVC);
   assign pready   = 1'b1;
   assign prdata   = s_q.rdata_q;
   assign pslverr  = acc & ~mapped;

   assign irq_overflow  = s_q.ovf_q & s_q.mask_q[TCC_FL_OVF];
   assign irq_compare_a = flag_a & s_q.mask_q[TCC_FL_CMPA];
   assign irq_compare_b = flag_b & s_q.mask_q[TCC_FL_CMPB];

   tcc_tick u_tick (
      .clk_sys             (clk_sys),
      .rst                 (rst),
      .clock_source_select (s_q.ctrl_b_q[TCC_CB_CS_LO +: 3]),
      .prescale_taps       (prescale_taps),
      .external_count_pin  (external_count_pin),
      .timer_tick          (timer_tick)
   );

   tcc_wave u_cmp_a (
      .clk_sys               (clk_sys),
      .rst                   (rst),
      .timer_tick            (timer_tick),
      .count                 (s_q.count_q),
      .up                    (s_q.dir_q == TCC_DIR_UP),
      .buffered              (fast_pwm | pc_pwm),
      .fast_pwm              (fast_pwm),
      .pc_pwm                (pc_pwm),
      .at_top                (at_top),
      .at_bottom             (at_bottom),
      .block_match           (s_q.block_q),
      .compare_output_action (s_q.ctrl_a_q[TCC_CA_COMA_LO +: 2]),
      .wr_en                 (wr_cmp_a),
      .wr_data               (pwdata[7:0]),
      .force_compare_strobe  (force_a),
      .flag_clr              (clr_a),
      .cpu_view              (view_a),
      .compare_value_reg     (cmp_a),
      .match                 (match_a),
      .flag                  (flag_a),
      .pin                   (compare_output_pin_a)
   );

   tcc_wave u_cmp_b (
      .clk_sys               (clk_sys),
      .rst                   (rst),
      .timer_tick            (timer_tick),
      .count                 (s_q.count_q),
      .up                    (s_q.dir_q == TCC_DIR_UP),
      .buffered              (fast_pwm | pc_pwm),
      .fast_pwm              (fast_pwm),
      .pc_pwm                (pc_pwm),
      .at_top                (at_top),
      .at_bottom             (at_bottom),
      .block_match           (s_q.block_q),
      .compare_output_action (s_q.ctrl_a_q[TCC_CA_COMB_LO +: 2]),
      .wr_en                 (wr_cmp_b),
      .wr_data               (pwdata[7:0]),
      .force_compare_strobe  (force_b),
      .flag_clr              (clr_b),
      .cpu_view              (view_b),
      .compare_value_reg     (),
      .match                 (match_b),
      .flag                  (flag_b),
      .pin                   (compare_output_pin_b)
   );

   always_comb begin
      s_d     = s_q;
      hit_ovf = 1'b0;
      // counting sequence, only on a tick
      if (timer_tick) begin
         s_d.block_q = 1'b0;
         if (pc_pwm) begin
            unique case (s_q.dir_q)
               TCC_DIR_UP: begin
                  if (at_top) begin
                     s_d.dir_q   = TCC_DIR_DOWN;
                     s_d.count_q = s_q.count_q - 8'h01;
                  end else begin
                     s_d.count_q = s_q.count_q + 8'h01;
                  end
               end
               TCC_DIR_DOWN: begin
                  if (at_bottom) begin
                     s_d.dir_q   = TCC_DIR_UP;
                     s_d.count_q = s_q.count_q + 8'h01;
                     hit_ovf     = 1'b1;
                  end else begin
                     s_d.count_q = s_q.count_q - 8'h01;
                  end
               end
               default: s_d.dir_q = TCC_DIR_UP;
            endcase
         end else begin
            s_d.dir_q = TCC_DIR_UP;
            if (top_is_a && match_a && !s_q.block_q) begin
               s_d.count_q = TCC_BOTTOM;
               hit_ovf     = fast_pwm;
            end else begin
               s_d.count_q = s_q.count_q + 8'h01;
               hit_ovf     = at_max;
            end
         end
      end
      // software count write wins over the sequence
      if (wr_count) begin
         s_d.count_q = pwdata[7:0];
         s_d.block_q = 1'b1;
      end
      if (wr && paddr == TCC_OFF_CTRL_A) begin
         s_d.ctrl_a_q = pwdata[7:0];
      end
      // force strobes are write-only, never stored
      if (wr && paddr == TCC_OFF_CTRL_B) begin
         s_d.ctrl_b_q = {2'h0, pwdata[5:0]};
      end
      if (wr && paddr == TCC_OFF_MASK) begin
         s_d.mask_q = pwdata[2:0];
      end
      if ((wr && paddr == TCC_OFF_FLAG && pwdata[TCC_FL_OVF]) || svc_overflow) begin
         s_d.ovf_q = 1'b0;
      end
      if (hit_ovf) begin
         s_d.ovf_q = 1'b1;
      end
      // read data captured during setup, shown in access
      s_d.err_q   = 1'b0;
      s_d.rdata_q = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            TCC_OFF_CTRL_A: s_d.rdata_q = {24'h0, s_q.ctrl_a_q};
            TCC_OFF_CTRL_B: s_d.rdata_q = {24'h0, s_q.ctrl_b_q};
            TCC_OFF_COUNT:  s_d.rdata_q = {24'h0, s_q.count_q};
            TCC_OFF_CMP_A:  s_d.rdata_q = {24'h0, view_a};
            TCC_OFF_CMP_B:  s_d.rdata_q = {24'h0, view_b};
            TCC_OFF_MASK:   s_d.rdata_q = {29'h0, s_q.mask_q};
            TCC_OFF_FLAG:   s_d.rdata_q = {29'h0, flag_b, flag_a, s_q.ovf_q};
            TCC_OFF_SVC:    s_d.rdata_q = {24'h0, at_max, at_bottom, at_top, 2'h0, waveform_mode_select};
            default:        s_d.rdata_q = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q       <= '0;
         s_q.dir_q <= TCC_DIR_UP;
      end else begin
         s_q <= s_d;
      end
   end

   a_count_hold_stop: assert property (@(posedge clk_sys) disable iff (rst)
      (!timer_tick && !wr_count) |=> s_q.count_q == $past(s_q.count_q)) else $error("count moved without tick");
   a_write_wins: assert property (@(posedge clk_sys) disable iff (rst)
      wr_count |=> s_q.count_q == $past(pwdata[7:0])) else $error("count write lost");
   a_normal_wrap: assert property (@(posedge clk_sys) disable iff (rst)
      (timer_tick && !wr_count && waveform_mode_select == TCC_WM_NORMAL && at_max)
      |=> s_q.count_q == TCC_BOTTOM && s_q.ovf_q) else $error("normal wrap wrong");
   a_ctc_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (timer_tick && !wr_count && waveform_mode_select == TCC_WM_CTC && match_a && !s_q.block_q)
      |=> s_q.count_q == TCC_BOTTOM) else $error("ctc clear missing");
   a_block_after_write: assert property (@(posedge clk_sys) disable iff (rst)
      (timer_tick && s_q.block_q && match_b && !flag_b && !clr_b) |=> !flag_b)
      else $error("match not blocked");
   a_irq_mask: assert property (@(posedge clk_sys) disable iff (rst)
      irq_compare_a == (flag_a && s_q.mask_q[TCC_FL_CMPA])) else $error("irq mask wrong");
endmodule : tcc_core

// ===== tcc_pins_model.sv
// far-side model: prescaler taps and external count pin
`timescale 1ns/1ps
module tcc_pins_model (
   // system
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // level asked for by the bench
   input  wire logic       ext_level,
   // pins toward the timer
   output logic [4:0]      prescale_taps,
   output logic            external_count_pin
);
   logic [9:0] div_q;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q              <= 10'h000;
         external_count_pin <= 1'b0;
      end else begin
         div_q              <= div_q + 10'h001;
         external_count_pin <= ext_level;
      end
   end
   // tap 0 every cycle so the bench can predict tick counts
   assign prescale_taps = {div_q == 10'h3ff, div_q[7:0] == 8'hff, div_q[5:0] == 6'h3f,
                           div_q[2:0] == 3'h7, 1'b1};
endmodule : tcc_pins_model

// ===== timer8_compare_core_tb_top.sv
// self-checking bench for the 8-bit timer/compare core
`timescale 1ns/1ps
module timer8_compare_core_tb_top;
   import tcc_pkg::*;
   logic        clk_sys   = 1'b0;
   logic        rst       = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [11:0] paddr     = 12'h000;
   logic [31:0] pwdata    = 32'h0;
   logic [3:0]  pstrb     = 4'h0;
   logic        ext_level = 1'b0;
   logic [2:0]  svc       = 3'h0;
   logic [31:0] prdata, rd_q;
   logic        pready, pslverr, err_q, pin_a, pin_b, irq_o, irq_a, irq_b, ext_pin;
   logic [4:0]  taps;
   int          mismatches = 0;
   int          tests_run  = 0;

   initial forever #2.5 clk_sys = ~clk_sys;

   tcc_pins_model pins (.clk_sys(clk_sys), .rst(rst), .ext_level(ext_level),
      .prescale_taps(taps), .external_count_pin(ext_pin));
   tcc_core uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prescale_taps(taps), .external_count_pin(ext_pin),
      .compare_output_pin_a(pin_a), .compare_output_pin_b(pin_b), .irq_overflow(irq_o),
      .irq_compare_a(irq_a), .irq_compare_b(irq_b), .svc_overflow(svc[0]),
      .svc_compare_a(svc[1]), .svc_compare_b(svc[2]));

   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; the wait on pready is bounded
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd_q  = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 64) begin
         mismatches++;
         results();
      end
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      check(rd_q & m, exp);
   endtask : rd

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(TCC_OFF_COUNT, 32'hffffffff, 32'h0);
      rd(TCC_OFF_CMP_A, 32'hffffffff, 32'h0);
      rd(TCC_OFF_CMP_B, 32'hffffffff, 32'h0);
      rd(TCC_OFF_FLAG, 32'hffffffff, 32'h0);
      rd(12'h020, 32'hffffffff, 32'h0);
      check({31'h0, err_q}, 32'h1);
      done("reset");
      wr(TCC_OFF_COUNT, 32'h5a);
      repeat (20) @(posedge clk_sys);
      rd(TCC_OFF_COUNT, 32'hff, 32'h5a);
      apb(1'b1, TCC_OFF_COUNT, 32'h11, 4'h0);
      rd(TCC_OFF_COUNT, 32'hff, 32'h5a);
      wr(TCC_OFF_CTRL_A, 32'h03);
      wr(TCC_OFF_CTRL_B, 32'h08);
      wr(TCC_OFF_COUNT, 32'hff);
      rd(TCC_OFF_SVC, 32'hc7, 32'h87);
      wr(TCC_OFF_COUNT, 32'h00);
      rd(TCC_OFF_SVC, 32'hc7, 32'h47);
      // pwm mode: the write lands in the buffer only, never loaded while stopped
      wr(TCC_OFF_CMP_A, 32'h33);
      rd(TCC_OFF_CMP_A, 32'hff, 32'h33);
      done("stopped");
      // count written to 0xfe equals compare b: that match must be blocked
      wr(TCC_OFF_CTRL_A, 32'h00);
      wr(TCC_OFF_CTRL_B, 32'h00);
      rd(TCC_OFF_CMP_A, 32'hff, 32'h00);
      wr(TCC_OFF_CMP_A, 32'h02);
      wr(TCC_OFF_CMP_B, 32'hfe);
      wr(TCC_OFF_COUNT, 32'hfe);
      wr(TCC_OFF_CTRL_B, 32'h01);
      repeat (6) @(posedge clk_sys);
      wr(TCC_OFF_CTRL_B, 32'h00);
      rd(TCC_OFF_FLAG, 32'hff, 32'h03);
      wr(TCC_OFF_MASK, 32'h07);
      check({29'h0, irq_b, irq_a, irq_o}, 32'h3);
      wr(TCC_OFF_MASK, 32'h02);
      check({29'h0, irq_b, irq_a, irq_o}, 32'h2);
      wr(TCC_OFF_FLAG, 32'h00);
      rd(TCC_OFF_FLAG, 32'hff, 32'h03);
      wr(TCC_OFF_FLAG, 32'h01);
      rd(TCC_OFF_FLAG, 32'hff, 32'h02);
      svc <= 3'h2;
      @(posedge clk_sys);
      svc <= 3'h0;
      @(posedge clk_sys);
      rd(TCC_OFF_FLAG, 32'hff, 32'h00);
      check({31'h0, irq_a}, 32'h0);
      done("normal");
      wr(TCC_OFF_CMP_A, 32'h05);
      wr(TCC_OFF_COUNT, 32'h00);
      wr(TCC_OFF_CTRL_A, 32'h02);
      wr(TCC_OFF_CTRL_B, 32'h01);
      repeat (40) @(posedge clk_sys);
      wr(TCC_OFF_CTRL_B, 32'h00);
      apb(1'b0, TCC_OFF_COUNT, 32'h0, 4'h0);
      check({31'h0, rd_q[7:0] <= 8'h05}, 32'h1);
      rd(TCC_OFF_FLAG, 32'h03, 32'h02);
      wr(TCC_OFF_FLAG, 32'h07);
      done("clear on match");
      // toggle action on unit a, forced twice in normal mode
      wr(TCC_OFF_CTRL_A, 32'h40);
      for (int i = 0; i < 2; i++) begin
         wr(TCC_OFF_CTRL_B, 32'h80);
         check({30'h0, pin_b, pin_a}, (i == 0) ? 32'h1 : 32'h0);
      end
      rd(TCC_OFF_FLAG, 32'hff, 32'h00);
      done("force");
      wr(TCC_OFF_CTRL_A, 32'h00);
      wr(TCC_OFF_COUNT, 32'h00);
      for (int k = 0; k < 2; k++) begin
         wr(TCC_OFF_CTRL_B, (k == 0) ? 32'h07 : 32'h06);
         for (int i = 0; i < 3; i++) begin
            ext_level <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_level <= 1'b0;
            repeat (4) @(posedge clk_sys);
         end
         rd(TCC_OFF_COUNT, 32'hff, (k == 0) ? 32'h03 : 32'h06);
      end
      done("external pin");
      results();
   end
endmodule : timer8_compare_core_tb_top
